// *** ccr_cfg.svh ***
// constants for the configuration and scratch register bank
// How it works
// R1: mode bits 24:0 pass a two-stage synchroniser and are loaded over the first three cycles after reset release.
// R2: bits 2:0 hold the coherency algorithm code (010,011,100,101,111 valid; 000,001,110 reserved).
// R3: fields sit at 4:3,5,6,8:7,12:9,13,14,15,18:16,21:19 and bits 25:22 read zero.
// R4: bits 28:26 always read 011, a 32 Kbyte data cache.
// R5: bits 31:29 always read 011, a 32 K instruction cache.
// R6: load-linked operations never write the link scratch register.
// R7: the link scratch register stores a software write and returns it on read.
// R8: the mode-derived fields stay constant from the fourth cycle after reset release until the next reset.
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
`define CCR_IDX_CONFIG 8'h10
`define CCR_IDX_SCRATCH 8'h11
`define CCR_MODE_HI 24
`define CCR_MODE_W 25
`define CCR_RSV_HI 25
`define CCR_RSV_LO 22
`define CCR_DCACHE_HI 28
`define CCR_DCACHE_LO 26
`define CCR_ICACHE_HI 31
`define CCR_ICACHE_LO 29
`define CCR_CACHE_32K 3'h3
`define CCR_COH_HI 2
`define CCR_COH_LO 0
`define CCR_DEVNUM_HI 4
`define CCR_DEVNUM_LO 3
`define CCR_COHTGT_BIT 5
`define CCR_ELIM_BIT 6
`define CCR_MAXREQ_HI 8
`define CCR_MAXREQ_LO 7
`define CCR_SYSDIV_HI 12
`define CCR_SYSDIV_LO 9
`define CCR_L2BLK_BIT 13
`define CCR_L2ECC_BIT 14
`define CCR_ENDIAN_BIT 15
`define CCR_L2SIZE_HI 18
`define CCR_L2SIZE_LO 16
`define CCR_L2DIV_HI 21
`define CCR_L2DIV_LO 19
`define CCR_RSV_VAL 4'h0
`define CCR_CAPTURE_CYC 2'h3
`endif

// *** ccr_pkg.sv ***
// types for the configuration and scratch register bank
package ccr_pkg;
    typedef enum logic [2:0] {
        CCR_COH_RSV0 = 3'h0,
        CCR_COH_RSV1 = 3'h1,
        CCR_COH_UNCACHED = 3'h2,
        CCR_COH_NONCOHERENT = 3'h3,
        CCR_COH_EXCLUSIVE = 3'h4,
        CCR_COH_EXCL_ON_WRITE = 3'h5,
        CCR_COH_RSV6 = 3'h6,
        CCR_COH_ACCEL = 3'h7
    } ccr_coherency_e;
endpackage

// *** ccr_regs.sv ***
// configuration and link scratch registers on a wishbone slave
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "ccr_cfg.svh"
module ccr_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [24:0] mode_bits,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic wb_err_o,
    output ccr_pkg::ccr_coherency_e coherency_algo_field,
    output logic [31:0] config_word
);
    logic [24:0] mode_s1;
    logic [24:0] mode_s2;
    logic [24:0] mode_reg;
    logic in_reset;
    logic [31:0] link_scratch;
    logic req;
    logic hit_cfg;
    logic hit_scr;
    logic [31:0] cfg_value;
    logic [31:0] next_rdata;
    logic wr_scr;
    logic rd_req;
    logic mapped;
    // field views of the captured mode bits, plus the two fixed cache size codes
    logic [2:0] coh_code;
    logic [1:0] device_number_field;
    logic coherent_target_field;
    logic elimination_request_field;
    logic [1:0] max_requests_field;
    logic [3:0] sys_clock_divisor_field;
    logic l2_block_size_field;
    logic l2_correction_field;
    logic endianness_field;
    logic [2:0] l2_size;
    logic [2:0] l2_clock_divisor_field;
    logic [2:0] data_cache_size_field;
    logic [2:0] instr_cache_size_field;

    // mode pins come from outside the clock domain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s1 <= 25'h0;
            mode_s2 <= 25'h0;
        end else begin
            mode_s1 <= mode_bits;
            mode_s2 <= mode_s1;
        end
    end

    // held high for the first cycles after release so the synchronised
    // mode value has settled before it is frozen
    logic [1:0] rst_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= 2'h0;
        end else if (rst_cnt != `CCR_CAPTURE_CYC) begin
            rst_cnt <= rst_cnt + 2'h1;
        end
    end
    assign in_reset = (rst_cnt != `CCR_CAPTURE_CYC);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= 25'h0;
        end else if (in_reset) begin
            mode_reg <= mode_s2; // R1 R8
        end
    end

    // capture bits 24:22 are held in mode_reg but fall in the reserved span
    // of the config word, so the reserved field always reads back as zero
    assign coh_code = mode_reg[`CCR_COH_HI:`CCR_COH_LO]; // R2
    assign device_number_field =
        mode_reg[`CCR_DEVNUM_HI:`CCR_DEVNUM_LO]; // R3
    assign coherent_target_field = mode_reg[`CCR_COHTGT_BIT]; // R3
    assign elimination_request_field = mode_reg[`CCR_ELIM_BIT]; // R3
    assign max_requests_field =
        mode_reg[`CCR_MAXREQ_HI:`CCR_MAXREQ_LO]; // R3
    assign sys_clock_divisor_field =
        mode_reg[`CCR_SYSDIV_HI:`CCR_SYSDIV_LO]; // R3
    assign l2_block_size_field = mode_reg[`CCR_L2BLK_BIT]; // R3
    assign l2_correction_field = mode_reg[`CCR_L2ECC_BIT]; // R3
    assign endianness_field = mode_reg[`CCR_ENDIAN_BIT]; // R3
    assign l2_size = mode_reg[`CCR_L2SIZE_HI:`CCR_L2SIZE_LO]; // R3
    assign l2_clock_divisor_field =
        mode_reg[`CCR_L2DIV_HI:`CCR_L2DIV_LO]; // R3
    assign data_cache_size_field = `CCR_CACHE_32K; // R4
    assign instr_cache_size_field = `CCR_CACHE_32K; // R5

    always_comb begin
        cfg_value = 32'h0;
        cfg_value[`CCR_COH_HI:`CCR_COH_LO] = coh_code; // R2
        cfg_value[`CCR_DEVNUM_HI:`CCR_DEVNUM_LO] =
            device_number_field; // R3
        cfg_value[`CCR_COHTGT_BIT] = coherent_target_field; // R3
        cfg_value[`CCR_ELIM_BIT] = elimination_request_field; // R3
        cfg_value[`CCR_MAXREQ_HI:`CCR_MAXREQ_LO] =
            max_requests_field; // R3
        cfg_value[`CCR_SYSDIV_HI:`CCR_SYSDIV_LO] =
            sys_clock_divisor_field; // R3
        cfg_value[`CCR_L2BLK_BIT] = l2_block_size_field; // R3
        cfg_value[`CCR_L2ECC_BIT] = l2_correction_field; // R3
        cfg_value[`CCR_ENDIAN_BIT] = endianness_field; // R3
        cfg_value[`CCR_L2SIZE_HI:`CCR_L2SIZE_LO] = l2_size; // R3
        cfg_value[`CCR_L2DIV_HI:`CCR_L2DIV_LO] =
            l2_clock_divisor_field; // R3
        cfg_value[`CCR_RSV_HI:`CCR_RSV_LO] = `CCR_RSV_VAL; // R3
        cfg_value[`CCR_DCACHE_HI:`CCR_DCACHE_LO] =
            data_cache_size_field; // R4
        cfg_value[`CCR_ICACHE_HI:`CCR_ICACHE_LO] =
            instr_cache_size_field; // R5
    end
    assign config_word = cfg_value;
    assign coherency_algo_field = ccr_pkg::ccr_coherency_e'(coh_code); // R2

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_cfg = (wb_adr_i == {22'h0, `CCR_IDX_CONFIG, 2'h0});
    assign hit_scr = (wb_adr_i == {22'h0, `CCR_IDX_SCRATCH, 2'h0});
    assign mapped = hit_cfg || hit_scr;
    assign rd_req = req && !wb_we_i;
    // the scratch write lands at the edge at which the master samples ack
    assign wr_scr = wb_cyc_i && wb_stb_i && wb_we_i && hit_scr && wb_ack_o;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req && mapped;
            wb_err_o <= req && !mapped;
        end
    end

    // only software writes reach this register; no load-linked path exists
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_scratch <= 32'h0;
        end else if (wr_scr) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    link_scratch[8*b +: 8] <= wb_dat_i[8*b +: 8]; // R6 R7
                end
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        if (hit_cfg) begin
            next_rdata = cfg_value;
        end else if (hit_scr) begin
            next_rdata = link_scratch; // R7
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0;
        end else if (rd_req) begin
            wb_dat_o <= next_rdata;
        end else begin
            wb_dat_o <= 32'h0;
        end
    end

    // steps that the checks below use by name
    sequence scr_write;
        wr_scr && (wb_sel_i == 4'hF);
    endsequence

    sequence cfg_read;
        req && hit_cfg && !wb_we_i;
    endsequence

    sequence mapped_req;
        req && mapped;
    endsequence

    sequence unmapped_req;
        req && !mapped;
    endsequence

    sequence capture_step;
        in_reset;
    endsequence

    chk_dcache_size: assert property (@(posedge mclk) // R4
        disable iff (!rst_n)
        config_word[`CCR_DCACHE_HI:`CCR_DCACHE_LO] == 3'h3)
        else $error("data cache size code not 011");

    chk_icache_size: assert property (@(posedge mclk) // R5
        disable iff (!rst_n)
        config_word[`CCR_ICACHE_HI:`CCR_ICACHE_LO] == 3'h3)
        else $error("instruction cache size code not 011");

    chk_rsv_zero: assert property (@(posedge mclk) // R3
        disable iff (!rst_n)
        config_word[`CCR_RSV_HI:`CCR_RSV_LO] == 4'h0)
        else $error("reserved config bits not zero");

    chk_field_place: assert property (@(posedge mclk) // R3
        disable iff (!rst_n)
        config_word[`CCR_L2DIV_HI:0] == mode_reg[`CCR_L2DIV_HI:0])
        else $error("config field out of place");

    chk_coh_field: assert property (@(posedge mclk) // R2
        disable iff (!rst_n)
        coherency_algo_field == config_word[2:0])
        else $error("coherency field mismatch");

    chk_cnt_step: assert property (@(posedge mclk) // R1
        disable iff (!rst_n)
        capture_step |=> rst_cnt == $past(rst_cnt) + 2'h1)
        else $error("capture counter did not advance");

    chk_cnt_hold: assert property (@(posedge mclk) // R8
        disable iff (!rst_n)
        !in_reset |=> !in_reset)
        else $error("capture window reopened without reset");

    chk_mode_load: assert property (@(posedge mclk) // R1
        disable iff (!rst_n)
        capture_step |=> mode_reg == $past(mode_s2))
        else $error("mode fields not loaded during reset");

    chk_mode_hold: assert property (@(posedge mclk) // R8
        disable iff (!rst_n)
        !in_reset && !$past(in_reset) |-> $stable(mode_reg))
        else $error("mode fields changed after reset");

    chk_sync_path: assert property (@(posedge mclk) // R1
        disable iff (!rst_n)
        mode_s2 == $past(mode_s1))
        else $error("mode synchroniser skipped a stage");

    chk_ack_pulse: assert property (@(posedge mclk)
        disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_err_pulse: assert property (@(posedge mclk)
        disable iff (!rst_n)
        wb_err_o |=> !wb_err_o)
        else $error("err held longer than one cycle");

    chk_ack_err_excl: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err raised together");

    chk_map_ack: assert property (@(posedge mclk)
        disable iff (!rst_n)
        mapped_req |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged");

    chk_unmap_err: assert property (@(posedge mclk)
        disable iff (!rst_n)
        unmapped_req |=> wb_err_o && !wb_ack_o && wb_dat_o == 32'h0)
        else $error("unmapped request not refused");

    chk_idle_data: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data shown outside ack");

    chk_cfg_read: assert property (@(posedge mclk) // R1
        disable iff (!rst_n)
        cfg_read |=> wb_ack_o && wb_dat_o == $past(config_word))
        else $error("config read returned wrong data");

    chk_cfg_ro: assert property (@(posedge mclk) // R8
        disable iff (!rst_n)
        req && hit_cfg && wb_we_i && !in_reset |=> $stable(config_word))
        else $error("config changed by a software write");

    chk_scr_store: assert property (@(posedge mclk) // R7
        disable iff (!rst_n)
        scr_write |=> link_scratch == $past(wb_dat_i))
        else $error("scratch write not stored");

    chk_scr_keep: assert property (@(posedge mclk) // R6
        disable iff (!rst_n)
        !wr_scr |=> $stable(link_scratch))
        else $error("scratch changed without a write");

    chk_read_data: assert property (@(posedge mclk) // R7
        disable iff (!rst_n)
        req && hit_scr && !wb_we_i |=>
            wb_ack_o && wb_dat_o == $past(link_scratch))
        else $error("scratch read returned wrong data");

    // each byte lane follows its own select on a scratch write
    for (genvar b = 0; b < 4; b++) begin : g_lane
        chk_lane_write: assert property (@(posedge mclk) // R7
            disable iff (!rst_n)
            wr_scr |=> link_scratch[8*b +: 8] == ($past(wb_sel_i[b]) ?
                $past(wb_dat_i[8*b +: 8]) : $past(link_scratch[8*b +: 8])))
            else $error("scratch byte lane written wrongly");
    end
endmodule // ccr_regs

// *** tb_top.sv ***
// self-checking bench for the configuration and scratch register bank
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [24:0] mode_bits = 25'h0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    ccr_pkg::ccr_coherency_e coherency_algo_field;
    logic [31:0] config_word;
    logic [31:0] rd;
    logic [31:0] ex;
    logic [24:0] m;
    logic er;
    int failures = 0;
    int n_tests = 0;
    always #4 mclk = ~mclk;
    ccr_regs u_dut (.mclk(mclk), .rst_n(rst_n), .mode_bits(mode_bits),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .coherency_algo_field(coherency_algo_field),
        .config_word(config_word));
    task automatic end_sim;
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack or err is sampled
    task automatic bus(input logic we, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
        do @(posedge mclk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1
                                   && ++n < 20);
        if (n >= 20)
            failures++;
        rd = wb_dat_o;
        er = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    // mode inputs stay put well before and after release
    task automatic boot(input logic [24:0] mv);
        rst_n <= 1'b0;
        mode_bits <= mv;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    initial begin
        for (int k = 0; k < 8; k++) begin
            m = (k[0] ? 25'h1AAAAA8 : 25'h0555550) | 25'(k);
            ex = {3'h3, 3'h3, 4'h0, m[21:0]};
            boot(m);
            bus(1'b0, 32'h40, 32'h0, 4'hF);
            cmp(rd, ex);
            cmp({29'h0, coherency_algo_field}, 32'(k));
            cmp(config_word, ex);
        end
        bus(1'b0, 32'h44, 32'h0, 4'hF);
        cmp(rd, 32'h0);
        mode_bits <= ~m;
        bus(1'b1, 32'h40, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 32'h40, 32'h0, 4'hF);
        cmp(rd, ex);
        bus(1'b1, 32'h44, 32'hA5C30F96, 4'hF);
        bus(1'b1, 32'h44, 32'h12345678, 4'h5);
        bus(1'b0, 32'h44, 32'h0, 4'hF);
        cmp(rd, 32'hA5340F78);
        bus(1'b1, 32'h48, 32'h0000FFFF, 4'hF);
        cmp({31'h0, er}, 32'h1);
        bus(1'b0, 32'h42, 32'h0, 4'hF);
        cmp({er, rd[30:0]}, 32'h80000000);
        bus(1'b0, 32'h44, 32'h0, 4'hF);
        cmp(rd, 32'hA5340F78);
        end_sim;
    end
    initial begin
        repeat (4000) @(posedge mclk);
        failures++;
        end_sim;
    end
endmodule // tb_top
